/* File: hdl/event_log_pkg.sv */
package event_log_pkg;

    // history geometry
    localparam int unsigned HIST_DEPTH     = 10;
    localparam int unsigned CODE_W         = 8;
    localparam int unsigned LEVEL_W        = 12;
    localparam int unsigned N_CAUSE        = 5;
    localparam int unsigned N_TERM         = 6;

    // warning and error codes
    localparam logic [7:0]  CODE_OVERHEAT  = 8'h21;
    localparam logic [7:0]  CODE_UNDERVOLT = 8'h25;
    localparam logic [7:0]  CODE_OVERLOAD  = 8'h30;
    localparam logic [7:0]  CODE_PROHIBIT  = 8'h6c;
    localparam logic [7:0]  CODE_COMM_ERR  = 8'h84;

    // cause bit positions
    localparam int unsigned C_OVERHEAT     = 0;
    localparam int unsigned C_UNDERVOLT    = 1;
    localparam int unsigned C_OVERLOAD     = 2;
    localparam int unsigned C_PROHIBIT     = 3;
    localparam int unsigned C_COMM         = 4;

    // register byte offsets
    localparam logic [7:0]  OFS_UV_LEVEL   = 8'h00;
    localparam logic [7:0]  OFS_OL_LEVEL   = 8'h04;
    localparam logic [7:0]  OFS_STATUS     = 8'h08;
    localparam logic [7:0]  OFS_CLEAR      = 8'h0c;
    localparam logic [1:0]  REGION_CTRL    = 2'h0;
    localparam logic [1:0]  REGION_ALARM   = 2'h1;
    localparam logic [1:0]  REGION_WARN    = 2'h2;
    localparam logic [1:0]  REGION_COMM    = 2'h3;

    // clear register bits
    localparam int unsigned CLR_ALARM      = 0;
    localparam int unsigned CLR_WARN       = 1;
    localparam int unsigned CLR_COMM       = 2;

    // reset values and fixed level
    localparam logic [11:0] UV_LEVEL_RST   = 12'h5a0;
    localparam logic [11:0] OL_LEVEL_RST   = 12'h800;
    localparam logic [11:0] OVERHEAT_LEVEL = 12'h0c8;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } bus_req_s;

    typedef struct packed {
        logic [11:0] temperature;
        logic [11:0] supply_level;
        logic [11:0] load_torque;
    } sense_s;

    typedef struct packed {
        logic        test_mode;
        logic        three_wire_mode;
        logic        forward_run_input;
        logic        reverse_run_input;
        logic        start_stop;
        logic        run_brake;
        logic [5:0]  term_active;
        logic [5:0]  term_assign_change;
    } inputs_s;

    typedef struct packed {
        logic        frame_good;
        logic        framing_error;
        logic        block_check_character_error;
    } link_s;

endpackage : event_log_pkg

/* File: hdl/warning_and_event_history_logger.sv */
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module history_buf #(
    parameter int unsigned DEPTH  = 10,
    parameter int unsigned W      = 8,
    parameter bit          RETAIN = 1'b0
) (
    // clock and reset
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst_b,
    // control
    input  wire logic                  i_push,
    input  wire logic [W-1:0]          i_code,
    input  wire logic                  i_clear,
    // contents, index 0 newest
    output logic [DEPTH-1:0][W-1:0]    o_entries,
    output logic [4:0]                 o_count
);
    logic [DEPTH-1:0][W-1:0] entry_reg;
    logic [DEPTH-1:0][W-1:0] entry_next;
    logic [4:0]              count_reg;
    logic [4:0]              count_next;

    // a push in the clear cycle survives as the sole entry
    always_comb begin
        entry_next = entry_reg;
        count_next = count_reg;
        if (i_clear) begin
            entry_next = '0;
            count_next = 5'h00;
        end
        if (i_push) begin
            entry_next = {entry_next[DEPTH-2:0], i_code};
            if (count_next < 5'(DEPTH)) begin
                count_next = count_next + 5'h01;
            end
        end
    end

    generate
        if (RETAIN) begin : g_retained
            // retained contents ignore logic reset, like the non-volatile copy
            always_ff @(posedge i_core_clk) begin
                entry_reg <= entry_next;
                count_reg <= count_next;
            end
        end else begin : g_volatile
            always_ff @(posedge i_core_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    entry_reg <= '0;
                    count_reg <= 5'h00;
                end else begin
                    entry_reg <= entry_next;
                    count_reg <= count_next;
                end
            end
        end
    endgenerate

    assign o_entries = entry_reg;
    assign o_count   = count_reg;
endmodule : history_buf

module warning_and_event_history_logger #(
    parameter int unsigned DEPTH = event_log_pkg::HIST_DEPTH
) (
    // clock and reset
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst_b,
    // register port
    input  wire event_log_pkg::bus_req_s i_bus,
    output logic [31:0]                o_rdata,
    // sensed levels, operation inputs, serial link events
    input  wire event_log_pkg::sense_s  i_sense,
    input  wire event_log_pkg::inputs_s i_inputs,
    input  wire event_log_pkg::link_s   i_link,
    // alarm events from the protection logic
    input  wire logic                  i_alarm_event,
    input  wire logic [7:0]            i_alarm_code,
    // warning pin and present code
    output logic                       o_warning_output,
    output logic [7:0]                 o_warning_code
);
    localparam int unsigned NC = event_log_pkg::N_CAUSE;
    localparam logic [NC-1:0][7:0] CAUSE_CODE = {event_log_pkg::CODE_COMM_ERR,
                                                 event_log_pkg::CODE_PROHIBIT,
                                                 event_log_pkg::CODE_OVERLOAD,
                                                 event_log_pkg::CODE_UNDERVOLT,
                                                 event_log_pkg::CODE_OVERHEAT};

    logic [11:0]    uv_level_reg;
    logic [11:0]    ol_level_reg;
    logic           test_mode_reg;
    logic           prohibit_reg;
    logic           comm_warn_reg;
    logic [NC-1:0]  cause_now;
    logic [NC-1:0]  cause_reg;
    logic [NC-1:0]  rise;
    logic [NC-1:0]  pending_reg;
    logic [NC-1:0]  grant;
    logic [7:0]     grant_code;
    logic           warning_reg;
    logic [7:0]     warning_code_reg;
    logic [31:0]    rdata_reg;
    logic           link_err;
    logic           test_exit;
    logic           prohibit_set;
    logic           wr_clear;
    logic [2:0]     clr;
    logic [DEPTH-1:0][7:0] alarm_hist;
    logic [DEPTH-1:0][7:0] warn_hist;
    logic [DEPTH-1:0][7:0] comm_hist;
    logic [4:0]     alarm_count;
    logic [4:0]     warn_count;
    logic [4:0]     comm_count;

    // settable detection levels
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            uv_level_reg <= event_log_pkg::UV_LEVEL_RST;
            ol_level_reg <= event_log_pkg::OL_LEVEL_RST;
        end else if (i_bus.wr && i_bus.addr == event_log_pkg::OFS_UV_LEVEL) begin
            uv_level_reg <= i_bus.wdata[11:0];
        end else if (i_bus.wr && i_bus.addr == event_log_pkg::OFS_OL_LEVEL) begin
            ol_level_reg <= i_bus.wdata[11:0];
        end
    end

    // operation-prohibited cause; held until every offending input is off
    assign test_exit    = test_mode_reg && !i_inputs.test_mode;
    assign prohibit_set = (test_exit && (i_inputs.three_wire_mode
                              ? (i_inputs.start_stop && i_inputs.run_brake)
                              : (i_inputs.forward_run_input || i_inputs.reverse_run_input)))
                          || |(i_inputs.term_assign_change & i_inputs.term_active);

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            test_mode_reg <= 1'b0;
            prohibit_reg  <= 1'b0;
        end else begin
            test_mode_reg <= i_inputs.test_mode;
            if (prohibit_set) begin
                prohibit_reg <= 1'b1;
            end else if (!(i_inputs.forward_run_input || i_inputs.reverse_run_input ||
                           i_inputs.start_stop || i_inputs.run_brake || |i_inputs.term_active)) begin
                prohibit_reg <= 1'b0;
            end
        end
    end

    // link warning stands until a good frame arrives; a new error wins
    assign link_err = i_link.framing_error || i_link.block_check_character_error;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            comm_warn_reg <= 1'b0;
        end else if (link_err) begin
            comm_warn_reg <= 1'b1;
        end else if (i_link.frame_good) begin
            comm_warn_reg <= 1'b0;
        end
    end

    always_comb begin
        cause_now = '0;
        cause_now[event_log_pkg::C_OVERHEAT]  = i_sense.temperature > event_log_pkg::OVERHEAT_LEVEL;
        cause_now[event_log_pkg::C_UNDERVOLT] = i_sense.supply_level < uv_level_reg;
        cause_now[event_log_pkg::C_OVERLOAD]  = i_sense.load_torque > ol_level_reg;
        cause_now[event_log_pkg::C_PROHIBIT]  = prohibit_reg;
        cause_now[event_log_pkg::C_COMM]      = comm_warn_reg;
    end

    // each cause logs once per onset; simultaneous onsets queue, lowest bit first
    assign rise  = cause_now & ~cause_reg;
    assign grant = pending_reg & (~pending_reg + NC'(1));

    always_comb begin
        grant_code = 8'h00;
        for (int i = 0; i < NC; i++) begin
            if (grant[i]) begin
                grant_code = CAUSE_CODE[i];
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cause_reg   <= '0;
            pending_reg <= '0;
        end else begin
            cause_reg   <= cause_now;
            pending_reg <= (pending_reg & ~grant) | rise;
        end
    end

    // pin follows the causes directly; no reset action needed to drop it
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            warning_reg      <= 1'b0;
            warning_code_reg <= 8'h00;
        end else begin
            warning_reg      <= |cause_now;
            warning_code_reg <= 8'h00;
            for (int i = NC - 1; i >= 0; i--) begin
                if (cause_now[i]) begin
                    warning_code_reg <= CAUSE_CODE[i];
                end
            end
        end
    end

    // maintenance clear: one write, one bit per history
    assign wr_clear = i_bus.wr && i_bus.addr == event_log_pkg::OFS_CLEAR;
    assign clr      = wr_clear ? i_bus.wdata[2:0] : 3'h0;

    history_buf #(.DEPTH(DEPTH), .W(8), .RETAIN(1'b1)) u_alarm_hist (
        .i_core_clk (i_core_clk),
        .i_rst_b    (i_rst_b),
        .i_push     (i_alarm_event),
        .i_code     (i_alarm_code),
        .i_clear    (clr[event_log_pkg::CLR_ALARM]),
        .o_entries  (alarm_hist),
        .o_count    (alarm_count)
    );

    history_buf #(.DEPTH(DEPTH), .W(8), .RETAIN(1'b0)) u_warn_hist (
        .i_core_clk (i_core_clk),
        .i_rst_b    (i_rst_b),
        .i_push     (|pending_reg),
        .i_code     (grant_code),
        .i_clear    (clr[event_log_pkg::CLR_WARN]),
        .o_entries  (warn_hist),
        .o_count    (warn_count)
    );

    history_buf #(.DEPTH(DEPTH), .W(8), .RETAIN(1'b0)) u_comm_hist (
        .i_core_clk (i_core_clk),
        .i_rst_b    (i_rst_b),
        .i_push     (link_err),
        .i_code     (event_log_pkg::CODE_COMM_ERR),
        .i_clear    (clr[event_log_pkg::CLR_COMM]),
        .o_entries  (comm_hist),
        .o_count    (comm_count)
    );

    // monitor reads: region in addr[7:6], entry index in addr[5:2]
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= 32'h0000_0000;
            if (i_bus.rd) begin
                unique case (i_bus.addr[7:6])
                    event_log_pkg::REGION_CTRL: begin
                        if (i_bus.addr == event_log_pkg::OFS_UV_LEVEL) begin
                            rdata_reg <= {20'h0_0000, uv_level_reg};
                        end else if (i_bus.addr == event_log_pkg::OFS_OL_LEVEL) begin
                            rdata_reg <= {20'h0_0000, ol_level_reg};
                        end else if (i_bus.addr == event_log_pkg::OFS_STATUS) begin
                            rdata_reg <= {4'h0, comm_count, warn_count, alarm_count,
                                          warning_code_reg, cause_reg};
                        end
                    end
                    event_log_pkg::REGION_ALARM: begin
                        if (i_bus.addr[1:0] == 2'h0 && 5'(i_bus.addr[5:2]) < alarm_count) begin
                            rdata_reg <= {24'h00_0000, alarm_hist[i_bus.addr[5:2]]};
                        end
                    end
                    event_log_pkg::REGION_WARN: begin
                        if (i_bus.addr[1:0] == 2'h0 && 5'(i_bus.addr[5:2]) < warn_count) begin
                            rdata_reg <= {24'h00_0000, warn_hist[i_bus.addr[5:2]]};
                        end
                    end
                    event_log_pkg::REGION_COMM: begin
                        if (i_bus.addr[1:0] == 2'h0 && 5'(i_bus.addr[5:2]) < comm_count) begin
                            rdata_reg <= {24'h00_0000, comm_hist[i_bus.addr[5:2]]};
                        end
                    end
                endcase
            end
        end
    end

    assign o_rdata          = rdata_reg;
    assign o_warning_output = warning_reg;
    assign o_warning_code   = warning_code_reg;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    sequence s_lone_onset(int b);
        rise[b] && pending_reg == '0 && $onehot(rise);
    endsequence

    a_warn_follows_cause: assert property (|cause_now |=> o_warning_output)
        else $error("warning output missing while a cause stands");
    a_warn_self_clear: assert property (!(|cause_now) |=> !o_warning_output)
        else $error("warning output stayed on with no cause");
    a_overheat_code: assert property (s_lone_onset(0) |=> ##1 warn_hist[0] == 8'h21)
        else $error("overheat onset not logged as 21h");
    a_undervolt_code: assert property (s_lone_onset(1) |=> ##1 warn_hist[0] == 8'h25)
        else $error("undervoltage onset not logged as 25h");
    a_overload_code: assert property (s_lone_onset(2) |=> ##1 warn_hist[0] == 8'h30)
        else $error("overload onset not logged as 30h");
    a_prohibit_set: assert property (prohibit_set |=> prohibit_reg ##1 o_warning_output)
        else $error("operation-prohibited not raised");
    a_link_warning: assert property (link_err |=> comm_warn_reg ##1 o_warning_output)
        else $error("link error did not raise the warning");
    a_comm_log: assert property (link_err && !clr[2] |=> comm_hist[0] == 8'h84 &&
                                 comm_count == ($past(comm_count) == 5'(DEPTH) ? 5'(DEPTH)
                                                : $past(comm_count) + 5'h01))
        else $error("link error not logged as 84h");
    a_clear_empties: assert property (clr[1] && !(|pending_reg) |=> warn_count == 5'h00)
        else $error("warning history not erased by clear");
    a_depth_cap: assert property (warn_count <= 5'(DEPTH) && comm_count <= 5'(DEPTH))
        else $error("history count above depth");
    a_rdata_pulse: assert property (!i_bus.rd |=> o_rdata == 32'h0000_0000)
        else $error("read data outside the read answer cycle");
endmodule : warning_and_event_history_logger

`default_nettype wire

/* File: bench/controller_model.sv */
`timescale 1ns/1ps
`default_nettype none

module controller_model (
    // clock
    input  wire logic                i_core_clk,
    // register port
    output var event_log_pkg::bus_req_s o_bus,
    input  wire logic [31:0]         i_rdata
);

    initial begin
        o_bus = '0;
    end

    // idle address and data carry the inverse, so a stale value never reads as live
    task automatic wr_reg(input logic [7:0] addr, input logic [31:0] data);
        @(posedge i_core_clk);
        o_bus <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge i_core_clk);
        o_bus <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
    endtask : wr_reg

    // data stand only in the cycle after the strobe, so they are taken just after that edge
    task automatic rd_reg(input logic [7:0] addr, output logic [31:0] data);
        @(posedge i_core_clk);
        o_bus <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 32'h0};
        @(posedge i_core_clk);
        o_bus <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 32'hffffffff};
        #1;
        data = i_rdata;
    endtask : rd_reg

endmodule : controller_model

`default_nettype wire

/* File: bench/warning_and_event_history_logger_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin err_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module warning_and_event_history_logger_tb_top;

    logic                    clk;
    logic                    rst_b;
    event_log_pkg::bus_req_s bus;
    logic [31:0]             rdata;
    event_log_pkg::sense_s   sense;
    event_log_pkg::inputs_s  ins;
    event_log_pkg::link_s    link;
    logic                    alarm_ev;
    logic [7:0]              alarm_code;
    logic                    warn_out;
    logic [7:0]              warn_code;
    int                      err_count;
    int                      checked;
    int                      alarm_q[$];
    int                      warn_q[$];
    int                      link_q[$];
    logic [31:0]             d;
    logic [11:0]             lvl;

    warning_and_event_history_logger #(.DEPTH(event_log_pkg::HIST_DEPTH)) warning_and_event_history_logger_i (
        .i_core_clk       (clk),
        .i_rst_b          (rst_b),
        .i_bus            (bus),
        .o_rdata          (rdata),
        .i_sense          (sense),
        .i_inputs         (ins),
        .i_link           (link),
        .i_alarm_event    (alarm_ev),
        .i_alarm_code     (alarm_code),
        .o_warning_output (warn_out),
        .o_warning_code   (warn_code)
    );

    controller_model controller_model_i (
        .i_core_clk (clk),
        .o_bus      (bus),
        .i_rdata    (rdata)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    function automatic void push(ref int q[$], input int code);
        q.push_front(code);
        if (q.size() > 10) q.pop_back();
    endfunction : push

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    // four cycles cover the longest latency (prohibit event plus two)
    task automatic expect_warn(input logic on, input logic [7:0] code);
        repeat (4) @(posedge clk);
        #1;
        `CHK(warn_out, on)
        `CHK(warn_code, code)
    endtask : expect_warn

    task automatic step_sense(input logic [11:0] t, input logic [11:0] s, input logic [11:0] l,
                              input logic on, input logic [7:0] code);
        @(posedge clk);
        sense <= '{t, s, l};
        expect_warn(on, code);
    endtask : step_sense

    task automatic pulse_link(input int kind);
        @(posedge clk);
        link <= 3'(1 << kind);
        @(posedge clk);
        link <= '0;
    endtask : pulse_link

    task automatic pulse_alarm(input logic [7:0] code);
        @(posedge clk);
        alarm_ev <= 1'b1;
        alarm_code <= code;
        @(posedge clk);
        alarm_ev <= 1'b0;
        alarm_code <= ~code;
        push(alarm_q, code);
    endtask : pulse_alarm

    task automatic check_hist(input logic [1:0] region, input int lsb, input int q[$]);
        logic [31:0] v;
        controller_model_i.rd_reg(event_log_pkg::OFS_STATUS, v);
        `CHK((v >> lsb) & 32'h1f, 32'(q.size()))
        for (int i = 0; i < 10; i++) begin
            controller_model_i.rd_reg({region, 6'(4 * i)}, v);
            `CHK(v, (i < q.size()) ? 32'(q[i]) : 32'h0)
        end
    endtask : check_hist

    initial begin
        #300000;
        err_count++;
        final_report();
    end

    initial begin
        void'($urandom(32'hd57e));
        rst_b = 1'b0;
        sense = '{12'h010, 12'hfff, 12'h000};
        ins = '0;
        link = '0;
        alarm_ev = 1'b0;
        alarm_code = 8'h00;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        controller_model_i.wr_reg(event_log_pkg::OFS_CLEAR, 32'h1);
        controller_model_i.rd_reg(event_log_pkg::OFS_OL_LEVEL, d);
        `CHK(d, {20'h0, event_log_pkg::OL_LEVEL_RST})
        controller_model_i.rd_reg(8'h10, d);
        `CHK(d, 32'h0)
        step_sense(12'h0c8, 12'hfff, 12'h000, 1'b0, 8'h00);
        step_sense(12'h0c9, 12'hfff, 12'h000, 1'b1, 8'h21);
        push(warn_q, 8'h21);
        step_sense(12'h0c8, 12'hfff, 12'h000, 1'b0, 8'h00);
        lvl = 12'($urandom_range(32'hfff, 32'h100));
        controller_model_i.wr_reg(event_log_pkg::OFS_UV_LEVEL, {20'h0, lvl});
        controller_model_i.rd_reg(event_log_pkg::OFS_UV_LEVEL, d);
        `CHK(d, {20'h0, lvl})
        step_sense(12'h010, lvl, 12'h000, 1'b0, 8'h00);
        step_sense(12'h010, lvl - 12'h1, 12'h000, 1'b1, 8'h25);
        push(warn_q, 8'h25);
        step_sense(12'h010, 12'hfff, 12'h000, 1'b0, 8'h00);
        lvl = 12'($urandom_range(32'hffe, 32'h100));
        controller_model_i.wr_reg(event_log_pkg::OFS_OL_LEVEL, {20'h0, lvl});
        step_sense(12'h010, 12'hfff, lvl, 1'b0, 8'h00);
        step_sense(12'h010, 12'hfff, lvl + 12'h1, 1'b1, 8'h30);
        push(warn_q, 8'h30);
        step_sense(12'h010, 12'hfff, 12'h000, 1'b0, 8'h00);
        // simultaneous onsets log lowest cause first, output shows the higher priority code
        step_sense(12'h0c9, 12'hfff, lvl + 12'h1, 1'b1, 8'h21);
        push(warn_q, 8'h21);
        push(warn_q, 8'h30);
        for (int i = 0; i < 5; i++) begin
            step_sense(12'h010, 12'hfff, 12'h000, 1'b0, 8'h00);
            step_sense(12'h0c9, 12'hfff, 12'h000, 1'b1, 8'h21);
            push(warn_q, 8'h21);
        end
        step_sense(12'h010, 12'hfff, 12'h000, 1'b0, 8'h00);
        // forward, reverse, then three-wire start and run-brake held at test exit
        for (int k = 0; k < 3; k++) begin
            @(posedge clk) ins <= {1'b1, k == 2, k == 0, k == 1, k == 2, k == 2, 12'h000};
            @(posedge clk) ins.test_mode <= 1'b0;
            expect_warn(1'b1, 8'h6c);
            push(warn_q, 8'h6c);
            @(posedge clk) ins <= '0;
            expect_warn(1'b0, 8'h00);
        end
        @(posedge clk) ins.term_active <= 6'h04;
        @(posedge clk) ins.term_assign_change <= 6'h02;
        @(posedge clk) ins.term_assign_change <= 6'h00;
        expect_warn(1'b0, 8'h00);
        @(posedge clk) ins.term_assign_change <= 6'h04;
        @(posedge clk) ins.term_assign_change <= 6'h00;
        expect_warn(1'b1, 8'h6c);
        push(warn_q, 8'h6c);
        @(posedge clk) ins <= '0;
        expect_warn(1'b0, 8'h00);
        for (int i = 0; i < 12; i++) begin
            pulse_link(i % 2);
            push(link_q, 8'h84);
        end
        push(warn_q, 8'h84);
        expect_warn(1'b1, 8'h84);
        pulse_link(2);
        expect_warn(1'b0, 8'h00);
        check_hist(2'h3, 23, link_q);
        check_hist(2'h2, 18, warn_q);
        for (int i = 0; i < 12; i++) begin
            pulse_alarm(8'($urandom));
        end
        check_hist(2'h1, 13, alarm_q);
        controller_model_i.wr_reg(event_log_pkg::OFS_CLEAR, 32'h2);
        warn_q.delete();
        check_hist(2'h2, 18, warn_q);
        check_hist(2'h1, 13, alarm_q);
        controller_model_i.wr_reg(event_log_pkg::OFS_CLEAR, 32'h1);
        alarm_q.delete();
        check_hist(2'h1, 13, alarm_q);
        check_hist(2'h3, 23, link_q);
        controller_model_i.wr_reg(event_log_pkg::OFS_CLEAR, 32'h4);
        link_q.delete();
        check_hist(2'h3, 23, link_q);
        // power loss: volatile histories vanish, retained alarm history survives
        pulse_link(1);
        push(link_q, 8'h84);
        push(warn_q, 8'h84);
        pulse_alarm(8'h5a);
        expect_warn(1'b1, 8'h84);
        // entries must stand before the power loss, or their absence after it proves nothing
        check_hist(2'h2, 18, warn_q);
        check_hist(2'h3, 23, link_q);
        @(posedge clk) rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        warn_q.delete();
        link_q.delete();
        expect_warn(1'b0, 8'h00);
        check_hist(2'h2, 18, warn_q);
        check_hist(2'h3, 23, link_q);
        check_hist(2'h1, 13, alarm_q);
        final_report();
    end

endmodule : warning_and_event_history_logger_tb_top

`default_nettype wire
